// *** hdl/pcw_defines.svh ***
// Register map, field positions and reset values of the PWM and wave unit.
// Assumes an 8-bit register port with 4-bit addresses and a 20 MHz clock.
// How it works
// - Control bit 7 runs or stops the PWM stage.
// - Control bit 5 reads back the PWM output level.
// - Control bit 4 set makes the PWM output active-low.
// - Duty high register holds duty 9..2, low register bits 7..6 hold 1..0.
// - Unused control and duty-low bits read as zero.
// - Reset clears control bits; duty registers are not reset.
// - Wave mode field picks one of six modes.
// - Half-bridge drives A true, B inverted, dead band between.
// - Half-bridge C and D follow A and B with own polarity.
// - Push-pull sends input pulses alternately to A and B.
// - Push-pull sequencer restarts on disable or shutdown.
// - First pulse after sequencer restart goes to A.
// - Push-pull C and D copy A and B with own polarity.
// - Forward bridge: A active, B and C idle, D modulated.
// - Reverse bridge: C active, A and D idle, B modulated.
// - Full-bridge dead band only on direction change.
// - Lowest mode bit flips direction while the unit runs.
// - Two independent 6-bit dead-band timers, rising and falling.
// - Shutdown forces every wave output to zero, except steered-off pins in modes 0 and 1.
// - Steering either at next rising input or at once.
// - Dead band counts clocks from zero up to its register.
// - Mode 0 steers at once, mode 1 at next rising input.
// - Disabled PWM output sits at its polarity level.
`ifndef PCW_DEFINES_SVH
`define PCW_DEFINES_SVH
`define PCW_ADDR_PWM_CTRL 4'h0
`define PCW_ADDR_DUTY_HI 4'h1
`define PCW_ADDR_DUTY_LO 4'h2
`define PCW_ADDR_WAVE_1 4'h3
`define PCW_ADDR_WAVE_2 4'h4
`define PCW_ADDR_DB_RISE 4'h5
`define PCW_ADDR_DB_FALL 4'h6
`define PCW_ADDR_STEER 4'h7
`define PCW_BYTE_ZERO 8'h00
`define PCW_PWM_EN_BIT 7
`define PCW_PWM_OUT_BIT 5
`define PCW_PWM_POL_BIT 4
`define PCW_DUTY_LO_MSB 7
`define PCW_DUTY_LO_LSB 6
`define PCW_WAVE_EN_BIT 7
`define PCW_WAVE_LD_BIT 6
`define PCW_MODE_MSB 2
`define PCW_MODE_LSB 0
`define PCW_POL_MSB 3
`define PCW_POL_LSB 0
`define PCW_INSEL_BIT 4
`define PCW_SD_STAT_BIT 6
`define PCW_SW_SD_BIT 7
`define PCW_DB_MSB 5
`define PCW_DB_LSB 0
`endif

// *** hdl/pcw_pkg.sv ***
// Types shared by the PWM stage and the complementary wave unit.
// Assumes nothing beyond the register map header.
package pcw_pkg;
  // One register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } pcw_bus_type;
  // Four wave outputs, A in bit 0
  typedef struct packed {
    logic d;
    logic c;
    logic b;
    logic a;
  } pcw_wave_type;
  // Wave unit modes
  typedef enum logic [2:0] {
    PCW_STEER_ASYNC = 3'h0,
    PCW_STEER_SYNC = 3'h1,
    PCW_BRIDGE_FWD = 3'h2,
    PCW_BRIDGE_REV = 3'h3,
    PCW_HALF = 3'h4,
    PCW_PUSH_PULL = 3'h5
  } pcw_mode_type;
  // Push-pull sequencer states
  typedef enum logic [2:0] {
    PCW_PP_IDLE = 3'h1,
    PCW_PP_ON_A = 3'h2,
    PCW_PP_ON_B = 3'h4
  } pcw_pp_type;
endpackage

// *** hdl/pcw_deadband.sv ***
// One dead-band timer: holds its output for a programmed number of clocks.
// Assumes start is a one-cycle pulse on the system clock.
`timescale 1ns/10ps
module pcw_deadband #(
  parameter int DB_W = 6
)(
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [DB_W-1:0] value,
  output logic hold
);
  logic active_reg;
  logic [DB_W-1:0] cnt_reg;
  logic [DB_W-1:0] lim_reg;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      active_reg <= 1'b0;
      cnt_reg <= '0;
      lim_reg <= '0;
    end
    else if (start)
    begin
      active_reg <= (value > 1);
      cnt_reg <= {{(DB_W-1){1'b0}}, 1'b1};
      lim_reg <= value;
    end
    else if (active_reg)
    begin
      active_reg <= (cnt_reg != lim_reg - 1'b1);
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  // Start cycle counts as count zero, so the hold lasts value clocks
  assign hold = (start && (value != '0)) || active_reg;

  default clocking dbClk @(posedge clk); endclocking
  default disable iff (rst);
  a_db_stops_at: assert property (
    active_reg && !start && cnt_reg == lim_reg - 1'b1 |=> !active_reg)
    else $error("dead band overran its count");
  a_db_within: assert property (active_reg |-> cnt_reg < lim_reg)
    else $error("dead band count beyond limit");
endmodule

// *** hdl/pcw_pwm_core.sv ***
// PWM stage: free-running time base, double-buffered duty, polarity.
// Assumes duty is written by software and may change at any time.
`timescale 1ns/10ps
module pcw_pwm_core #(
  parameter int DUTY_W = 10
)(
  input wire logic clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic polarity,
  input wire logic [DUTY_W-1:0] dutyValue,
  output logic pwmLevel
);
  logic [DUTY_W-1:0] cnt_reg;
  logic [DUTY_W-1:0] dutyLatch_reg;

  // time base runs only while enabled
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      cnt_reg <= '0;
    else if (enable)
      cnt_reg <= cnt_reg + 1'b1;
    else
      cnt_reg <= '0;
  end

  // Duty latched at period end so a write never cuts a pulse short
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      dutyLatch_reg <= '0;
    else if (!enable || cnt_reg == '1)
      dutyLatch_reg <= dutyValue;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      pwmLevel <= 1'b0;
    else if (enable)
      pwmLevel <= (cnt_reg < dutyLatch_reg) ^ polarity;
    else
      pwmLevel <= polarity;
  end
endmodule

// *** hdl/pcw_top.sv ***
// PWM stage feeding a complementary wave unit with dead band and steering.
// Assumes a register port with one-cycle strobes and synchronous pins.
`timescale 1ns/10ps
`include "pcw_defines.svh"
module pcw_top #(
  parameter int DUTY_W = 10,
  parameter int DB_W = 6
)(
  input wire logic clk,
  input wire logic rst,
  input wire pcw_pkg::pcw_bus_type busReq,
  output logic [7:0] rdData,
  input wire logic waveIn,
  input wire logic shutdownIn,
  output logic pwmOut,
  output pcw_pkg::pcw_wave_type waveOut
);
  // Register copies, input tracking and per-mode intermediates
  logic pwmEn_reg, pwmPol_reg, pwmLevel, waveEn_reg, loadReq_reg, inSel_reg, swShut_reg;
  logic shut_reg, sync1_reg, inLvl_reg, inPrev_reg, rise, fall, dirRev_reg, dirNext;
  logic fbMode, wantRev, dirChange, loadDone, riseStart, fallStart, riseHold, fallHold;
  logic [7:0] dutyHigh_reg, steerSet_reg, steerUse_reg, steerCur, rd_next;
  logic [1:0] dutyLow_reg;
  logic [3:0] wavePol_reg, rawNext, wave_next;
  logic [DB_W-1:0] riseBuf_reg, fallBuf_reg, riseAct_reg, fallAct_reg;
  pcw_pkg::pcw_mode_type mode_reg;
  pcw_pkg::pcw_pp_type pp_reg, pp_next;

  // ******************************************
  // Register port
  // ******************************************

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pwmEn_reg <= 1'b0;
      pwmPol_reg <= 1'b0;
    end
    else if (busReq.wr && busReq.addr == `PCW_ADDR_PWM_CTRL)
    begin
      pwmEn_reg <= busReq.wdata[`PCW_PWM_EN_BIT];
      pwmPol_reg <= busReq.wdata[`PCW_PWM_POL_BIT];
    end
  end

  // duty survives reset, unknown at power-up
  always_ff @(posedge clk)
  begin
    if (busReq.wr && busReq.addr == `PCW_ADDR_DUTY_HI)
      dutyHigh_reg <= busReq.wdata;
    if (busReq.wr && busReq.addr == `PCW_ADDR_DUTY_LO)
      dutyLow_reg <= busReq.wdata[`PCW_DUTY_LO_MSB:`PCW_DUTY_LO_LSB];
  end

  // mode field and unit enable
  // Load request is set by software and cleared by hardware; the set wins
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      waveEn_reg <= 1'b0;
      mode_reg <= pcw_pkg::PCW_STEER_ASYNC;
      loadReq_reg <= 1'b0;
    end
    else
    begin
      if (busReq.wr && busReq.addr == `PCW_ADDR_WAVE_1)
      begin
        waveEn_reg <= busReq.wdata[`PCW_WAVE_EN_BIT];
        mode_reg <= pcw_pkg::pcw_mode_type'(busReq.wdata[`PCW_MODE_MSB:`PCW_MODE_LSB]);
      end
      if (busReq.wr && busReq.addr == `PCW_ADDR_WAVE_1 && busReq.wdata[`PCW_WAVE_LD_BIT])
        loadReq_reg <= 1'b1;
      else if (loadDone)
        loadReq_reg <= 1'b0;
    end
  end

  // per-output polarity, input select, software shutdown
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wavePol_reg <= '0;
      inSel_reg <= 1'b0;
      swShut_reg <= 1'b0;
    end
    else if (busReq.wr && busReq.addr == `PCW_ADDR_WAVE_2)
    begin
      wavePol_reg <= busReq.wdata[`PCW_POL_MSB:`PCW_POL_LSB];
      inSel_reg <= busReq.wdata[`PCW_INSEL_BIT];
      swShut_reg <= busReq.wdata[`PCW_SW_SD_BIT];
    end
  end

  // Dead-band and steering write buffers
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      riseBuf_reg <= '0;
      fallBuf_reg <= '0;
      steerSet_reg <= `PCW_BYTE_ZERO;
    end
    else if (busReq.wr)
    begin
      if (busReq.addr == `PCW_ADDR_DB_RISE)
        riseBuf_reg <= busReq.wdata[`PCW_DB_MSB:`PCW_DB_LSB];
      if (busReq.addr == `PCW_ADDR_DB_FALL)
        fallBuf_reg <= busReq.wdata[`PCW_DB_MSB:`PCW_DB_LSB];
      if (busReq.addr == `PCW_ADDR_STEER)
        steerSet_reg <= busReq.wdata;
    end
  end

  always_comb
  begin
    rd_next = `PCW_BYTE_ZERO;
    case (busReq.addr)
      `PCW_ADDR_PWM_CTRL:
      begin
        rd_next[`PCW_PWM_EN_BIT] = pwmEn_reg;
        rd_next[`PCW_PWM_OUT_BIT] = pwmLevel;
        rd_next[`PCW_PWM_POL_BIT] = pwmPol_reg;
      end
      `PCW_ADDR_DUTY_HI: rd_next = dutyHigh_reg;
      `PCW_ADDR_DUTY_LO: rd_next[`PCW_DUTY_LO_MSB:`PCW_DUTY_LO_LSB] = dutyLow_reg;
      `PCW_ADDR_WAVE_1:
      begin
        rd_next[`PCW_WAVE_EN_BIT] = waveEn_reg;
        rd_next[`PCW_WAVE_LD_BIT] = loadReq_reg;
        rd_next[`PCW_MODE_MSB:`PCW_MODE_LSB] = mode_reg;
      end
      `PCW_ADDR_WAVE_2:
      begin
        rd_next[`PCW_POL_MSB:`PCW_POL_LSB] = wavePol_reg;
        rd_next[`PCW_INSEL_BIT] = inSel_reg;
        rd_next[`PCW_SD_STAT_BIT] = shut_reg;
        rd_next[`PCW_SW_SD_BIT] = swShut_reg;
      end
      `PCW_ADDR_DB_RISE: rd_next[`PCW_DB_MSB:`PCW_DB_LSB] = riseBuf_reg;
      `PCW_ADDR_DB_FALL: rd_next[`PCW_DB_MSB:`PCW_DB_LSB] = fallBuf_reg;
      `PCW_ADDR_STEER: rd_next = steerSet_reg;
      default: rd_next = `PCW_BYTE_ZERO;
    endcase
  end

  // Read data stands one cycle only; zero otherwise
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rdData <= `PCW_BYTE_ZERO;
    else
      rdData <= busReq.rd ? rd_next : `PCW_BYTE_ZERO;
  end

  // ******************************************
  // PWM stage
  // ******************************************

  pcw_pwm_core #(.DUTY_W(DUTY_W)) uPwm (
    .clk(clk),
    .rst(rst),
    .enable(pwmEn_reg),
    .polarity(pwmPol_reg),
    .dutyValue({dutyHigh_reg, dutyLow_reg}),
    .pwmLevel(pwmLevel)
  );
  assign pwmOut = pwmLevel;

  // ******************************************
  // Wave unit input and timing
  // ******************************************

  // two-stage synchroniser, edge taken after the second
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sync1_reg <= 1'b0;
      inLvl_reg <= 1'b0;
      inPrev_reg <= 1'b0;
    end
    else
    begin
      sync1_reg <= inSel_reg ? waveIn : pwmLevel;
      inLvl_reg <= sync1_reg;
      inPrev_reg <= inLvl_reg;
    end
  end
  assign rise = inLvl_reg && !inPrev_reg;
  assign fall = !inLvl_reg && inPrev_reg;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      shut_reg <= 1'b0;
    else
      shut_reg <= swShut_reg || shutdownIn;
  end

  // Active dead-band values: direct while off, on falling input after a load request
  assign loadDone = waveEn_reg && loadReq_reg && fall;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      riseAct_reg <= '0;
      fallAct_reg <= '0;
    end
    else if (!waveEn_reg || loadDone)
    begin
      riseAct_reg <= riseBuf_reg;
      fallAct_reg <= fallBuf_reg;
    end
  end

  // direction follows the low mode bit at the next rising input
  assign fbMode = mode_reg == pcw_pkg::PCW_BRIDGE_FWD || mode_reg == pcw_pkg::PCW_BRIDGE_REV;
  assign wantRev = mode_reg == pcw_pkg::PCW_BRIDGE_REV;
  assign dirChange = waveEn_reg && fbMode && rise && (wantRev != dirRev_reg);
  assign dirNext = (fbMode && rise) ? wantRev : dirRev_reg;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      dirRev_reg <= 1'b0;
    else
      dirRev_reg <= dirNext;
  end

  // bridge dead band only on direction change
  // Reverse change uses the rising timer, forward change the falling one
  assign riseStart = waveEn_reg
    && ((mode_reg == pcw_pkg::PCW_HALF && rise) || (dirChange && wantRev));
  assign fallStart = waveEn_reg
    && ((mode_reg == pcw_pkg::PCW_HALF && fall) || (dirChange && !wantRev));

  pcw_deadband #(.DB_W(DB_W)) uRiseDb (
    .clk(clk),
    .rst(rst),
    .start(riseStart),
    .value(riseAct_reg),
    .hold(riseHold)
  );
  pcw_deadband #(.DB_W(DB_W)) uFallDb (
    .clk(clk),
    .rst(rst),
    .start(fallStart),
    .value(fallAct_reg),
    .hold(fallHold)
  );

  // ******************************************
  // Push-pull sequencer
  // ******************************************

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      pp_reg <= pcw_pkg::PCW_PP_IDLE;
    else
      pp_reg <= pp_next;
  end

  always_comb
  begin
    pp_next = pp_reg;
    if (!waveEn_reg || shut_reg)
      pp_next = pcw_pkg::PCW_PP_IDLE;
    else if (mode_reg == pcw_pkg::PCW_PUSH_PULL && rise)
      case (pp_reg)
        pcw_pkg::PCW_PP_IDLE: pp_next = pcw_pkg::PCW_PP_ON_A;
        pcw_pkg::PCW_PP_ON_A: pp_next = pcw_pkg::PCW_PP_ON_B;
        pcw_pkg::PCW_PP_ON_B: pp_next = pcw_pkg::PCW_PP_ON_A;
        default: pp_next = pcw_pkg::PCW_PP_IDLE;
      endcase
  end

  // ******************************************
  // Output forming
  // ******************************************

  // synchronous steering takes the new set on a rising input
  // mode 0 applies it at once
  assign steerCur = (mode_reg == pcw_pkg::PCW_STEER_ASYNC || rise) ? steerSet_reg : steerUse_reg;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      steerUse_reg <= `PCW_BYTE_ZERO;
    else
      steerUse_reg <= steerCur;
  end

  // Raw active levels per mode, A in bit 0
  always_comb
  begin
    rawNext = 4'h0;
    case (mode_reg)
      // true and inverted copies with dead band
      // C and D follow A and B
      pcw_pkg::PCW_HALF:
      begin
        rawNext[0] = inLvl_reg && !riseHold;
        rawNext[1] = !inLvl_reg && !fallHold;
        rawNext[2] = rawNext[0];
        rawNext[3] = rawNext[1];
      end
      // C and D copy A and B
      pcw_pkg::PCW_PUSH_PULL:
      begin
        rawNext[0] = inLvl_reg && pp_next == pcw_pkg::PCW_PP_ON_A;
        rawNext[1] = inLvl_reg && pp_next == pcw_pkg::PCW_PP_ON_B;
        rawNext[2] = rawNext[0];
        rawNext[3] = rawNext[1];
      end
      pcw_pkg::PCW_BRIDGE_FWD, pcw_pkg::PCW_BRIDGE_REV:
      begin
        rawNext[0] = !dirNext;
        rawNext[3] = !dirNext && inLvl_reg && !fallHold;
        rawNext[2] = dirNext;
        rawNext[1] = dirNext && inLvl_reg && !riseHold;
      end
      pcw_pkg::PCW_STEER_ASYNC, pcw_pkg::PCW_STEER_SYNC:
        rawNext = {4{inLvl_reg}};
      default: rawNext = 4'h0;
    endcase
  end

  // shutdown forces zero, polarity not applied to the override
  // Steered-off pins show their fixed level and ignore shutdown
  always_comb
  begin
    wave_next = 4'h0;
    for (int i = 0; i < 4; i++)
    begin
      if (!waveEn_reg)
        wave_next[i] = 1'b0;
      else if (!mode_reg[`PCW_MODE_MSB] && !mode_reg[1] && !steerCur[i])
        wave_next[i] = steerCur[i+4];
      else if (shut_reg)
        wave_next[i] = 1'b0;
      else
        wave_next[i] = rawNext[i] ^ wavePol_reg[i];
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      waveOut <= '0;
    else
      waveOut <= pcw_pkg::pcw_wave_type'(wave_next);
  end

  // ******************************************
  // Checks
  // ******************************************

  default clocking topClk @(posedge clk); endclocking
  default disable iff (rst);

  a_pwm_idle_level: assert property (
    !pwmEn_reg ##1 !pwmEn_reg |-> pwmOut == $past(pwmPol_reg))
    else $error("disabled PWM not at idle level");
  a_readback_out: assert property (
    busReq.rd && busReq.addr == `PCW_ADDR_PWM_CTRL |=>
    rdData[`PCW_PWM_OUT_BIT] == $past(pwmLevel))
    else $error("output readback mismatch");
  a_ctrl_reserved: assert property (
    busReq.rd && busReq.addr == `PCW_ADDR_PWM_CTRL |=>
    rdData[6] == 1'b0 && rdData[3:0] == 4'h0)
    else $error("reserved control bits not zero");
  // Watches the driven pins with polarity taken off, not the raw terms
  a_half_no_overlap: assert property (
    waveEn_reg && !shut_reg && mode_reg == pcw_pkg::PCW_HALF |=>
    !((waveOut.a ^ $past(wavePol_reg[0])) && (waveOut.b ^ $past(wavePol_reg[1]))))
    else $error("half-bridge outputs overlap");
  a_half_dead_band: assert property (
    waveEn_reg && !shut_reg && mode_reg == pcw_pkg::PCW_HALF && rise && riseAct_reg != '0
    |=> waveOut.a == $past(wavePol_reg[0]))
    else $error("half-bridge rising dead band skipped");
  a_pp_first_a: assert property (
    pp_reg == pcw_pkg::PCW_PP_IDLE && waveEn_reg && !shut_reg
    && mode_reg == pcw_pkg::PCW_PUSH_PULL && rise |=> pp_reg == pcw_pkg::PCW_PP_ON_A)
    else $error("first push-pull pulse not on A");
  a_pp_restart: assert property (
    !waveEn_reg || shut_reg |=> pp_reg == pcw_pkg::PCW_PP_IDLE)
    else $error("sequencer not restarted");
  a_fwd_static: assert property (
    waveEn_reg && !shut_reg && fbMode && !dirNext |=>
    waveOut.a == !$past(wavePol_reg[0]) && waveOut.c == $past(wavePol_reg[2]))
    else $error("forward static outputs wrong");
  a_rev_static: assert property (
    waveEn_reg && !shut_reg && fbMode && dirNext |-> rawNext[2] && !rawNext[0] && !rawNext[3])
    else $error("reverse static outputs wrong");
  a_shut_zero: assert property (
    waveEn_reg && shut_reg && mode_reg == pcw_pkg::PCW_HALF |=> waveOut == '0)
    else $error("shutdown left a drive active");
  a_async_steer: assert property (
    mode_reg == pcw_pkg::PCW_STEER_ASYNC |=> steerUse_reg == $past(steerSet_reg))
    else $error("immediate steering delayed");

  c_pp_alternate: cover property (pp_reg == pcw_pkg::PCW_PP_ON_A
    ##[1:200] pp_reg == pcw_pkg::PCW_PP_ON_B);
  c_dir_change: cover property (dirChange && riseHold);
  c_half_dead: cover property (mode_reg == pcw_pkg::PCW_HALF && waveEn_reg && fallHold);
  c_shutdown: cover property (waveEn_reg && $rose(shut_reg));
endmodule

// *** test/pcw_switch_model.sv ***
// Load model: gates of the power switches fed by the four wave outputs.
// Assumes the outputs change only just after the rising clock edge.
`timescale 1ns/10ps
module pcw_switch_model (
  input wire logic clk,
  input wire logic rst,
  input wire pcw_pkg::pcw_wave_type gate,
  input wire logic legCheck,
  output int aOnCnt,
  output int bOnCnt,
  output int shootCnt
);
  // ****************
  // Switch load
  // ****************
  pcw_pkg::pcw_wave_type lastGate_reg;

  // Count turn-ons; A and B on together would short the leg
  // no overlap
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      lastGate_reg <= '0;
      aOnCnt <= 0;
      bOnCnt <= 0;
      shootCnt <= 0;
    end
    else
    begin
      lastGate_reg <= gate;
      aOnCnt <= aOnCnt + int'(gate.a && !lastGate_reg.a);
      bOnCnt <= bOnCnt + int'(gate.b && !lastGate_reg.b);
      // Only meaningful in half-bridge and push-pull
      shootCnt <= shootCnt + int'(legCheck && gate.a && gate.b);
    end
  end
endmodule

// *** test/tb_pcw_top.sv ***
// Testbench for the PWM stage and wave unit, driven through the register port.
// Assumes the register map of the design and a switch load on the wave outputs.
`timescale 1ns/10ps
module tb_pcw_top;
  // ****************
  // Harness
  // ****************
  logic clk = 1'b0;
  logic rst = 1'b1;
  pcw_pkg::pcw_bus_type busReq = '0;
  logic [7:0] rdData;
  logic waveIn = 1'b0;
  logic shutdownIn = 1'b0;
  logic legCheck = 1'b0;
  logic pwmOut;
  pcw_pkg::pcw_wave_type waveOut;
  logic [3:0] mid;
  int errorCnt = 0;
  int checks = 0;
  int aOn, bOn, shoot, n, n2, hits, a0, b0;

  // 20 MHz clock
  always #25 clk = ~clk;

  pcw_top i_pcw_top (.clk(clk), .rst(rst), .busReq(busReq), .rdData(rdData),
    .waveIn(waveIn), .shutdownIn(shutdownIn), .pwmOut(pwmOut), .waveOut(waveOut));
  pcw_switch_model i_pcw_switch_model (.clk(clk), .rst(rst), .gate(waveOut),
    .legCheck(legCheck), .aOnCnt(aOn), .bOnCnt(bOn), .shootCnt(shoot));

  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      errorCnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Strobe dropped before the idle edge, so calls may follow at once
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    busReq <= '{1'b1, 1'b0, a, d};
    @(posedge clk);
    busReq <= '0;
    @(posedge clk);
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
    busReq <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk);
    busReq <= '0;
    @(posedge clk);
    chk($sformatf("register %h", a), rdData, exp);
  endtask

  // One input pulse, 12 clocks high then 12 low; n is first clock bit bi is on
  task automatic pulse(input int bi);
    n = 99;
    waveIn <= 1'b1;
    for (int i = 1; i <= 12; i++)
    begin
      @(posedge clk);
      if (waveOut[bi] === 1'b1 && n == 99)
        n = i;
    end
    mid = waveOut;
    waveIn <= 1'b0;
    repeat (12) @(posedge clk);
  endtask

  // Active clocks of the PWM output over one 1024-clock period
  task automatic pwmCount(input logic lvl);
    hits = 0;
    repeat (1024)
    begin
      @(posedge clk);
      if (pwmOut === lvl)
        hits++;
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checks, errorCnt);
    if (errorCnt == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Hang guard
  initial
  begin
    repeat (60000) @(posedge clk);
    errorCnt++;
    results();
  end

  // ****************
  // Scenarios
  // ****************
  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdc(4'h0, 8'h00);
    rdc(4'h8, 8'h00);
    wr(4'h2, 8'hFF);
    rdc(4'h2, 8'hC0);
    wr(4'h0, 8'h10);
    rdc(4'h0, 8'h30);
    chk("pwmOut", 8'(pwmOut), 8'h01);
    wr(4'h0, 8'h6F);
    rdc(4'h0, 8'h00);
    chk("pwmOut", 8'(pwmOut), 8'h00);
    wr(4'h1, 8'h00);
    wr(4'h2, 8'h80);
    rdc(4'h1, 8'h00);
    rdc(4'h2, 8'h80);
    wr(4'h0, 8'h80);
    pwmCount(1'b1);
    chk("pwmHigh", 8'(hits), 8'h02);
    repeat (10) @(posedge clk);
    rdc(4'h0, 8'h80);
    wr(4'h0, 8'h90);
    pwmCount(1'b0);
    chk("pwmLow", 8'(hits), 8'h02);
    wr(4'h0, 8'h00);
    $display("pwm stage done");
    // Half bridge from the pin input, C inverted, rising dead band 2
    wr(4'h4, 8'h14);
    wr(4'h5, 8'h02);
    wr(4'h6, 8'h00);
    wr(4'h3, 8'h84);
    legCheck <= 1'b1;
    pulse(0);
    chk("halfRise", 8'(n), 8'h06);
    chk("halfHigh", 8'(mid), 8'h01);
    chk("halfLow", 8'(waveOut), 8'h0E);
    wr(4'h3, 8'h04);
    wr(4'h5, 8'h06);
    wr(4'h3, 8'h84);
    pulse(0);
    chk("halfRise6", 8'(n), 8'h0A);
    // While running, a new dead band waits for the load request and a falling input
    wr(4'h5, 8'h02);
    wr(4'h3, 8'hC4);
    shutdownIn <= 1'b1;
    pulse(0);
    chk("halfShut", 8'(mid), 8'h00);
    rdc(4'h4, 8'h54);
    shutdownIn <= 1'b0;
    rdc(4'h3, 8'h84);
    pulse(0);
    chk("halfLoaded", 8'(n), 8'h06);
    $display("half bridge done");
    // Push-pull: A first, then alternating, restart on disable and shutdown
    wr(4'h4, 8'h10);
    wr(4'h3, 8'h85);
    a0 = aOn;
    b0 = bOn;
    for (int k = 0; k < 3; k++)
    begin
      pulse(k % 2);
      chk("pushPull", 8'(mid), (k % 2) ? 8'h0A : 8'h05);
    end
    chk("aPulses", 8'(aOn - a0), 8'h02);
    chk("bPulses", 8'(bOn - b0), 8'h01);
    wr(4'h3, 8'h05);
    wr(4'h3, 8'h85);
    pulse(0);
    chk("ppRestart", 8'(mid), 8'h05);
    shutdownIn <= 1'b1;
    repeat (3) @(posedge clk);
    shutdownIn <= 1'b0;
    repeat (3) @(posedge clk);
    pulse(0);
    chk("ppShutdown", 8'(mid), 8'h05);
    chk("shoot", 8'(shoot), 8'h00);
    legCheck <= 1'b0;
    $display("push-pull done");
    // Full bridge, dead band 3 only on the first pulse after reversal
    wr(4'h3, 8'h05);
    wr(4'h5, 8'h03);
    wr(4'h6, 8'h03);
    wr(4'h3, 8'h82);
    pulse(3);
    pulse(3);
    n2 = n;
    chk("forward", 8'(mid), 8'h09);
    wr(4'h3, 8'h83);
    pulse(1);
    chk("reverse", 8'(mid), 8'h06);
    chk("revDelay", 8'(n), 8'(n2 + 3));
    pulse(1);
    chk("revSteady", 8'(n), 8'(n2));
    $display("full bridge done");
    // Steering, immediate then synchronised to the next rising input
    wr(4'h7, 8'h0F);
    wr(4'h3, 8'h80);
    pulse(0);
    chk("steerAll", 8'(mid), 8'h0F);
    wr(4'h7, 8'hF0);
    @(posedge clk);
    chk("asyncFixed", 8'(waveOut), 8'h0F);
    wr(4'h7, 8'h00);
    @(posedge clk);
    chk("asyncZero", 8'(waveOut), 8'h00);
    wr(4'h3, 8'h81);
    wr(4'h7, 8'hF0);
    repeat (4) @(posedge clk);
    chk("syncWait", 8'(waveOut), 8'h00);
    pulse(0);
    chk("syncTaken", 8'(waveOut), 8'h0F);
    wr(4'h3, 8'h86);
    pulse(0);
    chk("spareMode", 8'(mid), 8'h00);
    $display("steering done");
    // Duty survives a reset, control does not
    wr(4'h1, 8'hA5);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdc(4'h1, 8'hA5);
    rdc(4'h0, 8'h00);
    $display("reset done");
    results();
  end
endmodule
